// file: verilog/l1d_cfg.svh
`ifndef L1D_CFG_SVH
`define L1D_CFG_SVH

// Register byte offsets on the APB window
`define L1D_OFF_CTRL 12'h000
`define L1D_OFF_STAT 12'h004

// Control register reset value and writable bits
`define L1D_CTRL_RST 32'h0000_0000
`define L1D_CTRL_WMASK 32'h0000_301e

// Control register bit positions
`define L1D_B_LOOKUP 1
`define L1D_B_RSV_LO 2
`define L1D_B_RSV_HI 3
`define L1D_B_STEER 4
`define L1D_B_PREF0 12
`define L1D_B_PREF1 13

// Cache reservation field codes
`define L1D_RSV_NONE 2'b00
`define L1D_RSV_BOTH 2'b11

// Requester slots, lowest index is highest nominal priority
`define L1D_NREQ 6
`define L1D_RQ_TEST 0
`define L1D_RQ_AG0 1
`define L1D_RQ_AG1 2
`define L1D_RQ_SB 3
`define L1D_RQ_DMA 4
`define L1D_RQ_FILL 5

// DMA starvation limit in core cycles and saturating counter ceiling
`define L1D_DMA_LIMIT 5'd16
`define L1D_DMA_CNT_MAX 5'd17
`define L1D_DMA_CNT_ONE 5'd1

// Address bits used for steering and collision keys
`define L1D_A_STEER0 14
`define L1D_A_STEER1 23
`define L1D_A_WPOL 2
`define L1D_A_HALF 16
`define L1D_A_SUB_HI 13
`define L1D_A_SUB_LO 12
`define L1D_A_BANK_HI 21
`define L1D_A_BANK_LO 20
`define L1D_A_SET_LO 5

// Address space decode: addr[31:22] region tags
`define L1D_REG_L1 10'h3fe
`define L1D_REG_MMR 10'h3ff
`define L1D_A_INBANK_HI 19
`define L1D_A_INBANK_LO 15

// Access sizes and page cache policies
`define L1D_SZ_HALF 2'b01
`define L1D_SZ_WORD 2'b10
`define L1D_SZ_DWORD 2'b11
`define L1D_POL_WTRD 2'b00
`define L1D_POL_WB 2'b10

`endif

// file: verilog/l1d_pkg.sv
package l1d_pkg;

	// One access request as presented by a requester
	typedef struct packed {
		logic valid;
		logic write;
		logic user;
		logic page_cache;
		logic [1:0] policy;
		logic [1:0] size;
		logic [31:0] addr;
	} l1d_req_t;

	// Per-requester arbitration and steering answer
	typedef struct packed {
		logic grant;
		logic cached;
		logic bank_a;
		logic alloc;
		logic wthru;
		logic tag_bit;
		logic [8:0] set_idx;
	} l1d_res_t;

	// Register bus phase
	typedef enum logic [0:0] {
		L1D_BUS_IDLE,
		L1D_BUS_ACC
	} l1d_bus_t;

endpackage

// file: verilog/l1d_bank_ctrl.sv
// Summary of operation
// - Unconflicted loads, store, DMA, fill all served together
// - Choice bit steers generator 1 uncached fetch port
// - Choice bit steers generator 0 uncached fetch port
// - Cached fetches use port of targeted bank
// - Bank steer only matters when both banks cache
// - Lookup enable bit gates all entries but test accesses, reset off
// - Minimal checks still fault reserved, misaligned, user-mode or generator 1 register access
// - Reset leaves everything but test accesses SRAM until reservation programmed
// - Caching needs lookup enabled and cacheable page
// - SRAM collision needs bits 2,13:12,16,21:20 equal
// - SRAM order: generators, store buffer, DMA/fill
// - DMA goes top after 17 blocked cycles or second queued
// - Cache two-way; second bank adds sets
// - Cache collision needs same subbank, half and bank
// - Cache order: test access, store buffer, fill
// - Per-page policy: WT read-alloc, WT both, WB
// - Both banks cache: two independent 16K two-way caches
// - Steer 0: bit 14 picks bank, bit 23 tagged
// - Steer 1: bit 23 picks bank, bit 14 tagged
// - Steer 0: one 32K cache, index from bits 13:5
// - Steer 1: alternating 8M regions, lowest to bank B
`timescale 1ns/1ps
`include "l1d_cfg.svh"

module l1d_bank_ctrl import l1d_pkg::*; (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire l1d_req_t [`L1D_NREQ-1:0] req,
	input wire logic dma_second_queued,
	output l1d_res_t [`L1D_NREQ-1:0] res,
	output logic [1:0] ag_port,
	output logic [1:0] ag_exc,
	output logic dma_boost
);

	logic [31:0] l1d_ctrl_reg_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	l1d_bus_t bus_r;
	logic [4:0] dma_wait_r;
	logic dma_boost_r;
	l1d_res_t [`L1D_NREQ-1:0] res_r;
	logic [1:0] ag_port_r;
	logic [1:0] ag_exc_r;

	// Decoded control fields
	logic protect_lookup_enable;
	logic [1:0] cache_reserve_field;
	logic bank_steer_select;
	logic gen0_port_choice;
	logic gen1_port_choice;
	logic boost_now;

	// Per-requester combinational results
	l1d_res_t [`L1D_NREQ-1:0] res_nxt;
	logic [`L1D_NREQ-1:0] cached;
	logic [`L1D_NREQ-1:0] valid;
	logic [5:0] key_s [`L1D_NREQ];
	logic [3:0] key_c [`L1D_NREQ];
	logic [`L1D_NREQ-1:0] blocked;
	logic [1:0] ag_port_nxt;
	logic [1:0] ag_exc_nxt;

	assign protect_lookup_enable = l1d_ctrl_reg_r[`L1D_B_LOOKUP];
	assign cache_reserve_field = l1d_ctrl_reg_r[`L1D_B_RSV_HI:`L1D_B_RSV_LO];
	assign bank_steer_select = l1d_ctrl_reg_r[`L1D_B_STEER];
	assign gen0_port_choice = l1d_ctrl_reg_r[`L1D_B_PREF0];
	assign gen1_port_choice = l1d_ctrl_reg_r[`L1D_B_PREF1];

	// Starvation promotion uses the registered wait count so it cannot loop combinationally
	assign boost_now = (dma_wait_r > `L1D_DMA_LIMIT) || dma_second_queued;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign res = res_r;
	assign ag_port = ag_port_r;
	assign ag_exc = ag_exc_r;
	assign dma_boost = dma_boost_r;

	// APB slave: one wait state, answer registered in the second access cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bus_r <= L1D_BUS_IDLE;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (ce) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			if (bus_r == L1D_BUS_IDLE) begin
				if (psel && penable) begin
					bus_r <= L1D_BUS_ACC;
					pready_r <= 1'b1;
					case (paddr)
						`L1D_OFF_CTRL: prdata_r <= l1d_ctrl_reg_r;
						`L1D_OFF_STAT: prdata_r <= {26'h0, dma_boost_r, dma_wait_r};
						default: begin
							prdata_r <= 32'h0000_0000;
							pslverr_r <= 1'b1;
						end
					endcase
				end
			end else begin
				bus_r <= L1D_BUS_IDLE;
			end
		end
	end

	// Control register; reserved bits are forced to zero so stray writes cannot set them
	// The write lands in the answer cycle, at the edge where the master sees pready
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			l1d_ctrl_reg_r <= `L1D_CTRL_RST;
		end else if (ce && bus_r == L1D_BUS_ACC && psel && penable && pwrite
				&& paddr == `L1D_OFF_CTRL) begin
			l1d_ctrl_reg_r <= pwdata & `L1D_CTRL_WMASK;
		end
	end

	// Per-requester steering, policy and collision keys
	genvar gi;
	generate
		for (gi = 0; gi < `L1D_NREQ; gi++) begin : g_req
			logic [31:0] a;
			logic bank;
			assign a = req[gi].addr;
			assign valid[gi] = req[gi].valid;

			// Bank choice only follows the steer bit when both banks cache
			always_comb begin
				if (cache_reserve_field == `L1D_RSV_BOTH) begin
					bank = bank_steer_select ? a[`L1D_A_STEER1] : a[`L1D_A_STEER0];
				end else begin
					bank = 1'b1;
				end
			end

			// Test accesses always land in the arrays; others need lookup and page attribute
			if (gi == `L1D_RQ_TEST) begin : g_test
				assign cached[gi] = 1'b1;
			end else begin : g_norm
				assign cached[gi] = protect_lookup_enable && req[gi].page_cache
					&& cache_reserve_field != `L1D_RSV_NONE;
			end

			assign key_s[gi] = {a[`L1D_A_WPOL], a[`L1D_A_SUB_HI:`L1D_A_SUB_LO], a[`L1D_A_HALF],
				a[`L1D_A_BANK_HI:`L1D_A_BANK_LO]};
			assign key_c[gi] = {bank, a[`L1D_A_SUB_HI:`L1D_A_SUB_LO], a[`L1D_A_HALF]};

			// A requester loses to any higher-ranked valid access in the same array with equal key
			always_comb begin
				blocked[gi] = 1'b0;
				for (int j = 0; j < `L1D_NREQ; j++) begin
					if (j != gi && valid[j] && cached[j] == cached[gi]
							&& (cached[gi] ? key_c[j] == key_c[gi] : key_s[j] == key_s[gi])
							&& (boost_now && !cached[gi]
								? (j == `L1D_RQ_DMA || (gi != `L1D_RQ_DMA && j < gi))
								: j < gi)) begin
						blocked[gi] = 1'b1;
					end
				end
			end

			// Unconflicted requesters are all granted in the same cycle
			always_comb begin
				res_nxt[gi].grant = valid[gi] && !blocked[gi];
				res_nxt[gi].cached = valid[gi] && cached[gi];
				res_nxt[gi].bank_a = bank;
				res_nxt[gi].tag_bit = bank_steer_select && cache_reserve_field == `L1D_RSV_BOTH
					? a[`L1D_A_STEER0] : a[`L1D_A_STEER1];
				res_nxt[gi].set_idx = a[`L1D_A_SUB_HI:`L1D_A_SET_LO];
				res_nxt[gi].alloc = cached[gi] && (!req[gi].write
					|| req[gi].policy != `L1D_POL_WTRD);
				res_nxt[gi].wthru = cached[gi] && req[gi].policy != `L1D_POL_WB;
			end
		end
	endgenerate

	// Address generator port choice and minimal address checks
	always_comb begin
		ag_port_nxt = 2'b00;
		ag_exc_nxt = 2'b00;
		for (int k = 0; k < 2; k++) begin
			logic [31:0] a;
			logic mis;
			logic rsvd;
			logic mmr;
			a = req[`L1D_RQ_AG0 + k].addr;
			mis = (req[`L1D_RQ_AG0 + k].size == `L1D_SZ_HALF && a[0])
				|| (req[`L1D_RQ_AG0 + k].size == `L1D_SZ_WORD && a[1:0] != 2'b00)
				|| (req[`L1D_RQ_AG0 + k].size == `L1D_SZ_DWORD && a[2:0] != 3'h0);
			rsvd = a[31:22] == `L1D_REG_L1 && (a[`L1D_A_BANK_HI]
				|| a[`L1D_A_INBANK_HI:`L1D_A_INBANK_LO] != 5'h00);
			mmr = a[31:22] == `L1D_REG_MMR && (k == 1 || req[`L1D_RQ_AG0 + k].user);
			ag_exc_nxt[k] = valid[`L1D_RQ_AG0 + k] && (mis || rsvd || mmr);
			if (cached[`L1D_RQ_AG0 + k]) begin
				ag_port_nxt[k] = !res_nxt[`L1D_RQ_AG0 + k].bank_a;
			end else begin
				ag_port_nxt[k] = (k == 0) ? gen0_port_choice : gen1_port_choice;
			end
		end
	end

	// Registered answers to requesters
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			res_r <= '0;
			ag_port_r <= 2'b00;
			ag_exc_r <= 2'b00;
		end else if (ce) begin
			res_r <= res_nxt;
			ag_port_r <= ag_port_nxt;
			ag_exc_r <= ag_exc_nxt;
		end
	end

	// DMA starvation counter, saturates so it never wraps back under the limit
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dma_wait_r <= 5'h00;
			dma_boost_r <= 1'b0;
		end else if (ce) begin
			dma_boost_r <= boost_now;
			if (valid[`L1D_RQ_DMA] && blocked[`L1D_RQ_DMA]) begin
				if (dma_wait_r != `L1D_DMA_CNT_MAX) begin
					dma_wait_r <= dma_wait_r + `L1D_DMA_CNT_ONE;
				end
			end else begin
				dma_wait_r <= 5'h00;
			end
		end
	end

	// Checks on the registered answers, one cycle after the request is taken
	generate
		for (gi = 0; gi < `L1D_NREQ; gi++) begin : g_chk
			free_grant_a: assert property (@(posedge clk_sys) disable iff (!resetn)
				ce && valid[gi] && !blocked[gi] |=> res_r[gi].grant)
				else $error("free request not granted");
		end
	endgenerate

	gen1_port_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && !cached[`L1D_RQ_AG1] |=> ag_port_r[1] == $past(gen1_port_choice))
		else $error("generator 1 port ignores choice bit");

	gen0_port_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && !cached[`L1D_RQ_AG0] |=> ag_port_r[0] == $past(gen0_port_choice))
		else $error("generator 0 port ignores choice bit");

	cached_port_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && cached[`L1D_RQ_AG0] |=> ag_port_r[0] == !res_r[`L1D_RQ_AG0].bank_a)
		else $error("cached fetch on wrong port");

	steer_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && cache_reserve_field != `L1D_RSV_BOTH |=> res_r[`L1D_RQ_AG0].bank_a)
		else $error("bank steer active without both banks");

	no_cache_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && !protect_lookup_enable && valid[`L1D_RQ_SB] |=> !res_r[`L1D_RQ_SB].cached)
		else $error("cached with lookup disabled");

	misalign_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && valid[`L1D_RQ_AG0] && req[`L1D_RQ_AG0].size == `L1D_SZ_WORD
		&& req[`L1D_RQ_AG0].addr[0] |=> ag_exc_r[0])
		else $error("misaligned access not faulted");

	dma_boost_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && valid[`L1D_RQ_DMA] && blocked[`L1D_RQ_DMA] && dma_wait_r == `L1D_DMA_LIMIT
		|=> boost_now)
		else $error("dma not promoted after limit");

	sram_order_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && !boost_now && valid[`L1D_RQ_AG0] && valid[`L1D_RQ_SB]
		&& !cached[`L1D_RQ_AG0] && !cached[`L1D_RQ_SB]
		&& key_s[`L1D_RQ_AG0] == key_s[`L1D_RQ_SB]
		|=> res_r[`L1D_RQ_AG0].grant && !res_r[`L1D_RQ_SB].grant)
		else $error("store buffer beat generator");

	bank_bit14_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && cache_reserve_field == `L1D_RSV_BOTH && !bank_steer_select
		|=> res_r[`L1D_RQ_AG1].bank_a == $past(req[`L1D_RQ_AG1].addr[`L1D_A_STEER0]))
		else $error("bank not chosen by bit 14");

	// Generators on distinct SRAM keys must both go through in one cycle
	sram_apart_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && !boost_now && valid[`L1D_RQ_AG0] && valid[`L1D_RQ_AG1]
		&& !cached[`L1D_RQ_AG0] && !cached[`L1D_RQ_AG1]
		&& key_s[`L1D_RQ_AG0] != key_s[`L1D_RQ_AG1]
		|=> res_r[`L1D_RQ_AG0].grant && res_r[`L1D_RQ_AG1].grant)
		else $error("distinct sram keys blocked a generator");

	// A promoted DMA transfer is never held back in SRAM
	dma_top_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && boost_now && valid[`L1D_RQ_DMA] && !cached[`L1D_RQ_DMA]
		|=> res_r[`L1D_RQ_DMA].grant)
		else $error("promoted dma not granted");

	// Array test accesses outrank the store buffer on a shared cache key
	test_first_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && valid[`L1D_RQ_TEST] && valid[`L1D_RQ_SB] && cached[`L1D_RQ_SB]
		&& key_c[`L1D_RQ_TEST] == key_c[`L1D_RQ_SB]
		|=> res_r[`L1D_RQ_TEST].grant && !res_r[`L1D_RQ_SB].grant)
		else $error("store buffer beat test access");

	// Fill traffic waits behind the store buffer in the cache arrays
	fill_last_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && valid[`L1D_RQ_SB] && valid[`L1D_RQ_FILL] && cached[`L1D_RQ_SB]
		&& cached[`L1D_RQ_FILL] && key_c[`L1D_RQ_SB] == key_c[`L1D_RQ_FILL]
		|=> !res_r[`L1D_RQ_FILL].grant)
		else $error("fill beat store buffer");

	// Steer set: bit 23 picks the bank, so the lowest region lands in bank B
	bank_bit23_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && cache_reserve_field == `L1D_RSV_BOTH && bank_steer_select
		|=> res_r[`L1D_RQ_AG1].bank_a == $past(req[`L1D_RQ_AG1].addr[`L1D_A_STEER1]))
		else $error("bank not chosen by bit 23");

	// Steer clear: the unused bit 23 must travel with the tag or hits would alias
	tag_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && cache_reserve_field == `L1D_RSV_BOTH && !bank_steer_select
		|=> res_r[`L1D_RQ_AG0].tag_bit == $past(req[`L1D_RQ_AG0].addr[`L1D_A_STEER1]))
		else $error("tag bit not taken from bit 23");

	// Write-back pages allocate on writes and never write through
	wb_policy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && cached[`L1D_RQ_SB] && req[`L1D_RQ_SB].policy == `L1D_POL_WB
		|=> res_r[`L1D_RQ_SB].alloc && !res_r[`L1D_RQ_SB].wthru)
		else $error("write-back page misdirected");

	// Generator 1 may never touch register space, even in supervisor mode
	mmr_gen1_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && valid[`L1D_RQ_AG1] && req[`L1D_RQ_AG1].addr[31:22] == `L1D_REG_MMR
		|=> ag_exc_r[1])
		else $error("register access by generator 1 not faulted");

	// With no reservation programmed every access except test accesses stays in SRAM
	sram_only_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && cache_reserve_field == `L1D_RSV_NONE && valid[`L1D_RQ_SB]
		|=> !res_r[`L1D_RQ_SB].cached)
		else $error("access cached with no reservation");

endmodule

// file: sim/l1d_agent_model.sv
`timescale 1ns/1ps
`include "l1d_cfg.svh"

// Stands in for the address generators, store buffer, DMA and fill engine
module l1d_agent_model import l1d_pkg::*; (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire l1d_req_t [`L1D_NREQ-1:0] cmd,
	output l1d_req_t [`L1D_NREQ-1:0] req
);
	logic [31:0] churn_r;

	// Changing pattern so an idle slot never repeats its last address
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			churn_r <= 32'h0000_0000;
		end else begin
			churn_r <= churn_r + 32'h9e37_79b9;
		end
	end

	// Live requests pass unchanged; idle slots carry junk addresses
	always_comb begin
		for (int i = 0; i < `L1D_NREQ; i++) begin
			req[i] = cmd[i];
			if (!cmd[i].valid) begin
				req[i].addr = ~cmd[i].addr ^ churn_r;
			end
		end
	end
endmodule

// file: sim/l1d_bank_ctrl_test.sv
`timescale 1ns/1ps
`include "l1d_cfg.svh"

module l1d_bank_ctrl_test import l1d_pkg::*;;
	logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, dma_q, dma_boost, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] ag_port, ag_exc;
	l1d_req_t [`L1D_NREQ-1:0] cmd, req, v;
	l1d_res_t [`L1D_NREQ-1:0] res;
	int err_count, total_checks, cyc, n;

	l1d_bank_ctrl uut (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .req(req), .dma_second_queued(dma_q), .res(res),
		.ag_port(ag_port), .ag_exc(ag_exc), .dma_boost(dma_boost));
	l1d_agent_model agents (.clk_sys(clk_sys), .resetn(resetn), .cmd(cmd), .req(req));

	// Core clock, 5 ns period
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Watchdog: the tests need well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Present requests at an edge; answers are registered at the next edge and read at the falling edge after it
	task automatic issue(input l1d_req_t [`L1D_NREQ-1:0] nv, input logic q);
		@(posedge clk_sys);
		cmd <= nv;
		dma_q <= q;
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	function automatic l1d_req_t mk(input logic [31:0] a, input logic pc, input logic [1:0] p);
		mk = '{valid: 1'b1, write: 1'b0, user: 1'b0, page_cache: pc, policy: p,
			size: `L1D_SZ_WORD, addr: a};
	endfunction

	function automatic logic [4:0] grants();
		grants = {res[5].grant, res[4].grant, res[3].grant, res[2].grant, res[1].grant};
	endfunction

	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		dma_q = 1'b0;
		cmd = '0;
		v = '0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		// Reset value, unmapped access, writable bits
		apb(1'b0, `L1D_OFF_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, 12'h008, 32'h0000_0000);
		check(err, 1'b1);
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_301e);
		apb(1'b0, `L1D_OFF_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_301e);
		$display("test registers done");
		// Uncached port choice, then cached traffic ignoring it
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_1000);
		v[1] = mk(32'h0000_0100, 1'b0, 2'b00);
		v[2] = mk(32'h0000_0104, 1'b0, 2'b00);
		issue(v, 1'b0);
		check(ag_port, 2'b01);
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_2000);
		issue(v, 1'b0);
		check(ag_port, 2'b10);
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_300e);
		v[1] = mk(32'h0000_4020, 1'b1, 2'b10);
		v[2] = mk(32'h0000_0024, 1'b1, 2'b10);
		issue(v, 1'b0);
		check(ag_port, 2'b10);
		$display("test ports done");
		// SRAM: spread keys all pass, shared key follows priority
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_0000);
		v = '0;
		for (int i = 1; i < 6; i++) begin
			v[i] = mk(32'hff80_0000 | 32'((i % 2) << 2) | 32'((i / 2) << 12), 1'b0, 2'b00);
		end
		issue(v, 1'b0);
		check(grants(), 5'b11111);
		for (int i = 1; i < 6; i++) begin
			v[i].addr = (i == 2) ? 32'hff80_0044 : 32'hff80_0040;
		end
		issue(v, 1'b0);
		check(grants(), 5'b00011);
		v[3].addr = 32'hff90_0040;
		issue(v, 1'b0);
		check(grants(), 5'b00111);
		v[1].valid = 1'b0;
		v[3].addr = 32'hff80_0040;
		issue(v, 1'b0);
		check(grants(), 5'b00110);
		$display("test sram done");
		// DMA promotion by a queued second transfer, then by starvation
		v = '0;
		v[1] = mk(32'hff80_0040, 1'b0, 2'b00);
		v[4] = mk(32'hff80_0040, 1'b0, 2'b00);
		issue(v, 1'b1);
		check(grants(), 5'b01000);
		check(dma_boost, 1'b1);
		issue(v, 1'b0);
		n = 1;
		while (res[`L1D_RQ_DMA].grant !== 1'b1 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		check(n, 18);
		check(dma_boost, 1'b1);
		$display("test dma done");
		// Cache arbitration: test access, store buffer, fill
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_000e);
		v = '0;
		v[0] = mk(32'h0000_4020, 1'b1, 2'b10);
		v[3] = v[0];
		v[5] = v[0];
		issue(v, 1'b0);
		check({res[5].grant, res[3].grant, res[0].grant}, 3'b001);
		v[5].addr = 32'h0000_5020;
		issue(v, 1'b0);
		check({res[5].grant, res[3].grant, res[0].grant}, 3'b101);
		// Bank steering under both steer settings
		v = '0;
		v[1] = mk(32'h0000_4020, 1'b1, 2'b10);
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, `L1D_OFF_CTRL, 32'h0000_000e | 32'(s << 4));
			issue(v, 1'b0);
			check({res[1].cached, res[1].bank_a, res[1].tag_bit, res[1].set_idx},
				{1'b1, !s, s == 1, 9'h001});
		end
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_0016);
		issue(v, 1'b0);
		check(res[1].bank_a, 1'b1);
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_000c);
		issue(v, 1'b0);
		check(res[1].cached, 1'b0);
		// Page policies on writes
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_000e);
		for (int p = 0; p < 3; p++) begin
			v[1] = mk(32'h0000_4020, 1'b1, 2'(p));
			v[1].write = 1'b1;
			issue(v, 1'b0);
			check({res[1].alloc, res[1].wthru}, {p != 0, p != 2});
		end
		$display("test cache done");
		// Minimal checks with lookup off
		apb(1'b1, `L1D_OFF_CTRL, 32'h0000_0000);
		v = '0;
		v[1] = mk(32'hff80_0001, 1'b0, 2'b00);
		v[2] = mk(32'hffc0_0000, 1'b0, 2'b00);
		issue(v, 1'b0);
		check(ag_exc, 2'b11);
		v[1] = mk(32'hff88_0000, 1'b0, 2'b00);
		v[2] = mk(32'hff80_1004, 1'b0, 2'b00);
		issue(v, 1'b0);
		check(ag_exc, 2'b01);
		$display("test faults done");
		tally_and_finish();
	end
endmodule
